// ---- lcd_host_model.sv ----
// Host model: Avalon-MM master, one transfer at a time.
// Assumes the slave answers within 20 cycles.
`timescale 1ns/100ps
module lcd_host_model (
   input wire logic mclk,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic hung
);
   // Idle bus at time zero
   initial {avs_address, avs_read, avs_write, avs_writedata, hung} = '0;
   // Request held until waitrequest seen low; data line inverted on release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk);
      {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      hung <= avs_waitrequest !== 1'b0;
      {avs_writedata, avs_write, avs_read} <= {~d, 2'b00};
   endtask
endmodule

// ---- lcd_ram_pkg.sv ----
// Contract
// - Per bank: 44 columns, 4/2/1 rows by mode
// - Stored one means element on, zero off
// - Column n feeds segment n; row feeds backplane
// - Eight rows: bank 0 rows 0-3, bank 1 rows 4-7
// - Bytes stored at once, grouped by mode
// - Load pointer first; byte starts at pointer
// - Pointer advances eight, four or two per byte
// - Stop at row end; drop overflowing bits
// - Discard bytes after row end; never wrap
// - Static: eight columns of row 0 or 4
// - Static: six bytes fill row, four bits dropped
// - 1:2: four columns over two rows per byte
// - 1:2 with bank 1: rows 4 and 5
// - 1:4: two columns over four rows per byte
// - 1:4 with bank 1: rows 4 to 7
// - Input and output bank held separately
// - Input bank picks where bytes land
// - Output bank picks rows driven out
// - Each display byte before row end lands at current pointer
//
// Package for the segment display RAM writer: sizes, register map, mode codes, carriers.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and word-aligned registers.
package lcd_ram_pkg;

   // Memory geometry
   localparam int NUM_COLUMNS = 44;
   localparam int NUM_ROWS = 8;
   localparam int BANK_ROWS = 4;
   localparam logic [6:0] LAST_COLUMN = 7'h2B;
   localparam int BITS_PER_BYTE = 8;

   // Multiplex mode field codes
   localparam logic [1:0] MODE_STATIC = 2'h0;
   localparam logic [1:0] MODE_HALF = 2'h1;
   localparam logic [1:0] MODE_QUARTER = 2'h2;

   // Pointer steps per mode
   localparam logic [3:0] STEP_STATIC = 4'h8;
   localparam logic [3:0] STEP_HALF = 4'h4;
   localparam logic [3:0] STEP_QUARTER = 4'h2;

   // Register byte offsets
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_POINTER = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_COLUMN_BASE = 8'h40;
   localparam logic [7:0] REG_COLUMN_LAST = 8'hEC;

   // Field positions
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_INPUT_BANK_BIT = 4;
   localparam int CFG_OUTPUT_BANK_BIT = 5;
   localparam int PTR_FULL_BIT = 8;

   // Reset values
   localparam logic [1:0] RESET_MODE = MODE_STATIC;
   localparam logic [5:0] RESET_POINTER = 6'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // Bank setting carrier
   typedef struct packed {
      logic output_bank_select;
      logic input_bank_select;
      logic [1:0] mode;
   } config_type;

   // Rows of the shown bank, row r feeds backplane r
   typedef struct packed {
      logic [BANK_ROWS-1:0][NUM_COLUMNS-1:0] rows;
   } shown_frame_type;

endpackage

// ---- lcd_ram_writer.sv ----
// Display RAM of a segment LCD driver with auto-incrementing pointer and two banks.
// Assumes an Avalon-MM master on mclk; display bytes arrive as writes to the data register.
`timescale 1ns/100ps
module lcd_ram_writer
   import lcd_ram_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output shown_frame_type shown_frame
);

   // Column offset of byte bit idx (idx 0 is the MSB)
   function automatic logic [2:0] bit_column_offset(input logic [1:0] mode, input logic [2:0] idx);
      case (mode)
         MODE_STATIC: bit_column_offset = idx;
         MODE_HALF: bit_column_offset = {1'b0, idx[2:1]};
         default: bit_column_offset = {2'b00, idx[2]};
      endcase
   endfunction

   // Row inside the bank of byte bit idx
   function automatic logic [1:0] bit_row_offset(input logic [1:0] mode, input logic [2:0] idx);
      case (mode)
         MODE_STATIC: bit_row_offset = 2'h0;
         MODE_HALF: bit_row_offset = {1'b0, idx[0]};
         default: bit_row_offset = idx[1:0];
      endcase
   endfunction

   // Pointer advance per stored byte
   function automatic logic [3:0] pointer_step(input logic [1:0] mode);
      case (mode)
         MODE_STATIC: pointer_step = STEP_STATIC;
         MODE_HALF: pointer_step = STEP_HALF;
         default: pointer_step = STEP_QUARTER;
      endcase
   endfunction

   // Display memory, one 44-bit word per row
   logic [NUM_ROWS-1:0][NUM_COLUMNS-1:0] ram;
   logic [NUM_ROWS-1:0][NUM_COLUMNS-1:0] next_ram;
   // Bank and mode settings
   config_type cfg;
   config_type next_cfg;
   // Write position and row-end flag
   logic [5:0] pointer;
   logic [5:0] next_pointer;
   logic row_full;
   logic next_row_full;
   // Bus answer state
   logic ack;
   logic next_ack;
   logic [31:0] readdata;
   logic [31:0] next_readdata;
   // Registered picture of the output bank
   shown_frame_type frame;
   shown_frame_type next_frame;

   // One wait state: request seen, answered on the next edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign avs_readdata = readdata;
   assign shown_frame = frame;

   // Next-value logic for bus, settings, pointer and memory
   always_comb begin
      logic [6:0] column;
      logic [6:0] advanced;
      logic [2:0] row;
      logic [5:0] read_column;
      column = 7'h00;
      advanced = 7'h00;
      row = 3'h0;
      read_column = 6'h00;
      next_ram = ram;
      next_cfg = cfg;
      next_pointer = pointer;
      next_row_full = row_full;
      next_readdata = readdata;
      next_ack = (avs_read | avs_write) & ~ack;
      // Read data prepared during the wait cycle
      if (avs_read && !ack) begin
         next_readdata = READ_ZERO;
         if (avs_address == REG_CONFIG) begin
            next_readdata[CFG_MODE_LSB +: 2] = cfg.mode;
            next_readdata[CFG_INPUT_BANK_BIT] = cfg.input_bank_select;
            next_readdata[CFG_OUTPUT_BANK_BIT] = cfg.output_bank_select;
         end else if (avs_address == REG_POINTER) begin
            next_readdata[5:0] = pointer;
            next_readdata[PTR_FULL_BIT] = row_full;
         end else if (avs_address >= REG_COLUMN_BASE && avs_address <= REG_COLUMN_LAST
                      && avs_address[1:0] == 2'h0) begin
            // Column readback: bit r is row r of that column
            read_column = 6'((avs_address - REG_COLUMN_BASE) >> 2);
            for (int r = 0; r < NUM_ROWS; r++) begin
               next_readdata[r] = ram[r][read_column];
            end
         end else begin
            // Unmapped or data register: reads as zero
            next_readdata = READ_ZERO;
         end
      end
      // Writes take effect on the answering edge only
      if (avs_write && ack) begin
         if (avs_address == REG_CONFIG) begin
            // Both bank flags written together, held apart
            next_cfg.mode = avs_writedata[CFG_MODE_LSB +: 2];
            next_cfg.input_bank_select = avs_writedata[CFG_INPUT_BANK_BIT];
            next_cfg.output_bank_select = avs_writedata[CFG_OUTPUT_BANK_BIT];
         end else if (avs_address == REG_POINTER) begin
            // Pointer load rearms writing
            next_pointer = avs_writedata[5:0];
            next_row_full = 1'b0;
         end else if (avs_address == REG_DATA) begin
            // Past the row end bytes are dropped whole
            if (!row_full) begin
               for (int i = 0; i < BITS_PER_BYTE; i++) begin
                  // MSB first, rows fastest, then columns
                  column = {1'b0, pointer} + {4'h0, bit_column_offset(cfg.mode, 3'(i))};
                  // Input bank picks rows 0-3 or 4-7
                  row = {cfg.input_bank_select, bit_row_offset(cfg.mode, 3'(i))};
                  // Bits beyond column 43 fall away
                  if (column <= LAST_COLUMN) begin
                     next_ram[row][column[5:0]] = avs_writedata[BITS_PER_BYTE-1-i];
                  end
               end
               advanced = {1'b0, pointer} + {3'h0, pointer_step(cfg.mode)};
               // Stop at the row end instead of wrapping
               if (advanced > LAST_COLUMN) begin
                  next_row_full = 1'b1;
               end else begin
                  next_pointer = advanced[5:0];
               end
            end
         end
      end
      // Output bank rows go to the drive logic
      for (int r = 0; r < BANK_ROWS; r++) begin
         next_frame.rows[r] = ram[{cfg.output_bank_select, 2'(r)}];
      end
   end

   // State registers, cleared display after reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         ram <= '0;
         cfg <= '{output_bank_select: 1'b0, input_bank_select: 1'b0, mode: RESET_MODE};
         pointer <= RESET_POINTER;
         row_full <= 1'b0;
         ack <= 1'b0;
         readdata <= READ_ZERO;
         frame <= '0;
      end else begin
         ram <= next_ram;
         cfg <= next_cfg;
         pointer <= next_pointer;
         row_full <= next_row_full;
         ack <= next_ack;
         readdata <= next_readdata;
         frame <= next_frame;
      end
   end

endmodule

// ---- lcd_ram_writer_asserts.sv ----
// Port checker for the display RAM writer.
// Assumes one wait state per bus request.
`timescale 1ns/100ps
module lcd_ram_writer_asserts
   import lcd_ram_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire shown_frame_type shown_frame
);
   // One domain, reset masks all
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire req = avs_read | avs_write; // Any request
   wire rdy = avs_read & ~avs_waitrequest; // Read answered
   a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait too long");
   a_wait_new: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest)
      else $error("no wait state");
   a_idle_free: assert property (!req |-> !avs_waitrequest)
      else $error("idle wait");
   a_data_zero: assert property (rdy && avs_address == REG_DATA |-> avs_readdata == READ_ZERO)
      else $error("data read not zero");
   a_hole_zero: assert property (rdy && avs_address == 8'h0C |-> avs_readdata == READ_ZERO)
      else $error("hole read not zero");
   a_config_clean: assert property (rdy && avs_address == REG_CONFIG |-> avs_readdata[31:6] == 26'h0)
      else $error("config spare bits set");
   a_frame_cause: assert property ($changed(shown_frame) |-> $past(avs_write && !avs_waitrequest, 2))
      else $error("frame moved without write");
   a_read_cause: assert property ($changed(avs_readdata) |-> $past(avs_read))
      else $error("readdata moved without read");
   // Main scenarios
   c_data: cover property (avs_write && !avs_waitrequest && avs_address == REG_DATA);
   c_column: cover property (rdy && avs_address >= REG_COLUMN_BASE);
   c_frame: cover property ($changed(shown_frame));
endmodule
bind lcd_ram_writer lcd_ram_writer_asserts u_chk (.mclk(mclk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .shown_frame(shown_frame));

// ---- lcd_ram_writer_test.sv ----
// Bench: fills every mode and bank, checks columns, pointer and shown rows.
// Assumes the host model for bus cycles and the bound checker.
`timescale 1ns/100ps
module lcd_ram_writer_test;
   import lcd_ram_pkg::*;
   logic mclk = 1'b0; // 20 MHz clock
   logic rst = 1'b1; // Reset, 3 cycles
   logic [7:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, hung;
   logic [31:0] avs_writedata, avs_readdata, q;
   shown_frame_type shown_frame;
   logic [7:0] em [NUM_COLUMNS]; // Expected columns, bit r is row r
   logic [5:0] ep; // Expected pointer
   logic ef; // Expected row end flag
   int bad_count = 0;
   int checks = 0;
   always #25 mclk = ~mclk;
   lcd_ram_writer uut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .shown_frame(shown_frame));
   lcd_host_model u_host (.mclk(mclk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .hung(hung));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chkf(input shown_frame_type g, input shown_frame_type e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Set banks and mode, load pointer, send n bytes, then read all back
   task automatic run(input logic [5:0] cfg, input logic [5:0] p, input int n);
      logic [7:0] d;
      shown_frame_type sf;
      int g;
      int c;
      g = cfg[1:0] == MODE_STATIC ? 1 : cfg[1:0] == MODE_HALF ? 2 : 4;
      u_host.xfer(1'b1, REG_CONFIG, {26'h0, cfg}, q);
      u_host.xfer(1'b1, REG_POINTER, {26'h0, p}, q);
      ep = p;
      ef = 1'b0;
      for (int k = 0; k < n; k++) begin
         d = 8'(k * 29) ^ 8'h5A;
         u_host.xfer(1'b1, REG_DATA, {24'h0, d}, q);
         // MSB first, rows fastest; past the row end nothing lands
         for (int i = 0; i < 8 && !ef; i++) begin
            c = ep + i / g;
            if (c <= 43) em[c][i % g + 4 * cfg[4]] = d[7 - i];
         end
         if (ef || ep + 8 / g > 43) ef = 1'b1;
         else ep = ep + 6'(8 / g);
      end
      u_host.xfer(1'b0, REG_POINTER, 32'h0, q);
      chk(q, {23'h0, ef, 2'h0, ep});
      for (int k = 0; k < NUM_COLUMNS; k++) begin
         u_host.xfer(1'b0, 8'(REG_COLUMN_BASE + 4 * k), 32'h0, q);
         chk(q, {24'h0, em[k]});
      end
      for (int k = 0; k < 176; k++) sf.rows[k / 44][k % 44] = em[k % 44][k / 44 + 4 * cfg[5]];
      chkf(shown_frame, sf);
      $display("test done config %h pointer %h", cfg, p);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // A hung transfer ends the run
   always @(posedge hung) begin
      bad_count++;
      finish_test();
   end
   // Main sequence: reset values, a hole, all modes and banks, row ends
   initial begin
      for (int k = 0; k < NUM_COLUMNS; k++) em[k] = 8'h00;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      u_host.xfer(1'b0, REG_CONFIG, 32'h0, q);
      chk(q, READ_ZERO);
      u_host.xfer(1'b0, REG_POINTER, 32'h0, q);
      chk(q, READ_ZERO);
      u_host.xfer(1'b0, REG_DATA, 32'h0, q);
      chk(q, READ_ZERO);
      u_host.xfer(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
      u_host.xfer(1'b0, 8'h0C, 32'h0, q);
      chk(q, READ_ZERO);
      $display("test done reset values and unmapped hole");
      for (int t = 0; t < 6; t++) run({t % 2 == 0, t % 2 == 1, 2'h0, 2'(t / 2)}, 6'h00, (6 << (t / 2)) + 1);
      run(6'h00, 6'h2A, 2);
      run(6'h22, 6'h2B, 1);
      run(6'h11, 6'h32, 1);
      finish_test();
   end
endmodule
